// *** inc/vic_pkg.sv ***
package vic_pkg;

  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int NSRC   = 20;
  localparam int SRC_W  = 5;
  localparam int LVL_W  = 3;
  localparam int NLVL   = 8;
  localparam int NFIELD = 24;

  // ----------------------------------------------------------------
  // Register byte addresses
  // ----------------------------------------------------------------
  localparam logic [31:0] OFS_BASE = 32'hFFFF0014;
  localparam logic [31:0] OFS_VEC  = 32'hFFFF001C;
  localparam logic [31:0] OFS_PA   = 32'hFFFF0020;
  localparam logic [31:0] OFS_PB   = 32'hFFFF0024;
  localparam logic [31:0] OFS_PC   = 32'hFFFF0028;
  localparam logic [31:0] OFS_CTRL = 32'hFFFF0030;
  localparam logic [31:0] OFS_STAT = 32'hFFFF003C;

  // ----------------------------------------------------------------
  // Writable bits and reset values
  // ----------------------------------------------------------------
  localparam logic [31:0] MASK_PA   = 32'h07777070;
  localparam logic [31:0] MASK_PB   = 32'h77777700;
  localparam logic [31:0] MASK_PC   = 32'h00007777;
  localparam logic [31:0] MASK_BASE = 32'h0000FFFF;
  localparam logic [31:0] MASK_CTRL = 32'h00000003;
  localparam logic [31:0] RST_REG   = 32'h00000000;
  localparam logic [7:0]  RST_STAT  = 8'h00;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int BIT_NORMAL_NEST = 0;
  localparam int BIT_FAST_NEST   = 1;
  localparam int VEC_SRC_LSB     = 2;
  localparam int VEC_BASE_LSB    = 7;
  localparam int VEC_BASE_MSB    = 22;
  localparam int PRIO_STRIDE     = 4;

  // ----------------------------------------------------------------
  // Source number to priority field index (field = reg * 8 + nibble)
  // ----------------------------------------------------------------
  localparam logic [4:0]  FIELD_NONE   = 5'h1F;
  localparam logic [2:0]  UNPRIO_LEVEL = 3'h7;
  localparam logic [4:0]  TIMER1_SRC   = 5'h08;
  localparam logic [99:0] SRC_FIELD    = {
    5'h1F, 5'h13, 5'h12, 5'h11, 5'h10, 5'h0F, 5'h0E, 5'h0D, 5'h0C, 5'h0B,
    5'h0A, 5'h04, 5'h1F, 5'h1F, 5'h1F, 5'h06, 5'h05, 5'h03, 5'h01, 5'h1F};

endpackage

// *** inc/winner_if.sv ***
`timescale 1ns/10ps
interface winner_if;
  logic       valid;
  logic [4:0] src;
  logic [2:0] level;
  modport producer (output valid, output src, output level);
  modport consumer (input valid, input src, input level);
endinterface

// *** rtl/prio_select.sv ***
`timescale 1ns/10ps
module prio_select #(
  parameter int NSRC = 20
) (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic [NSRC-1:0]   eligible,
  input  wire logic [3*NSRC-1:0] levels,
  winner_if.producer             w
);

  logic       best_valid;
  logic [4:0] best_src;
  logic [2:0] best_lvl;

  // Strict compare keeps the lowest source number on a level tie
  always_comb
  begin
    best_valid = 1'b0;
    best_src   = 5'h00;
    best_lvl   = 3'h7;
    for (int i = 0; i < NSRC; i++)
    begin
      if (eligible[i] && (!best_valid || levels[3*i +: 3] < best_lvl))
      begin
        best_valid = 1'b1;
        best_src   = 5'(i);
        best_lvl   = levels[3*i +: 3];
      end
    end
  end

  assign w.valid = best_valid;
  assign w.src   = best_src;
  assign w.level = best_lvl;

  property p_src_range;
    @(posedge pclk) disable iff (!presetn)
    w.valid |-> (w.src <= 5'h13) && eligible[w.src];
  endproperty
  a_src_range: assert property (p_src_range) else $error("winner source out of range");

  property p_tie_low;
    @(posedge pclk) disable iff (!presetn)
    w.valid && (w.src != 5'h00) |-> !(eligible[w.src-1] && levels[3*(w.src-1) +: 3] == w.level);
  endproperty
  a_tie_low: assert property (p_tie_low) else $error("tie not resolved to lowest source");

endmodule // prio_select

// *** rtl/nest_status.sv ***
`timescale 1ns/10ps
module nest_status (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       set_en,
  input  wire logic [2:0] set_level,
  input  wire logic       clr_en,
  input  wire logic [7:0] clr_mask,
  output logic [7:0]      stat_q,
  output logic [7:0]      blocked
);

  logic [7:0] stat_d;
  wire  [7:0] cand     = stat_q & clr_mask;
  wire  [7:0] clr_pick = cand & (~cand + 8'h01);
  wire  [7:0] set_vec  = set_en ? (8'h01 << set_level) : 8'h00;

  // Set is applied after the clear so a set in the same cycle is kept
  assign stat_d = (stat_q & ~(clr_en ? clr_pick : 8'h00)) | set_vec;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      stat_q <= vic_pkg::RST_STAT;
    else
      stat_q <= stat_d;
  end

  for (genvar l = 0; l < 8; l++)
  begin : g_block
    assign blocked[l] = |stat_q[l:0];
  end

  property p_one_clear;
    @(posedge pclk) disable iff (!presetn)
    clr_en && !set_en && (cand != 8'h00) |=>
      ($countones(stat_q) == $countones($past(stat_q)) - 1) && ((stat_q & ~$past(stat_q)) == 8'h00);
  endproperty
  a_one_clear: assert property (p_one_clear) else $error("status write did not clear one bit");

  property p_set_bit;
    @(posedge pclk) disable iff (!presetn)
    set_en |=> stat_q[$past(set_level)];
  endproperty
  a_set_bit: assert property (p_set_bit) else $error("nesting bit not set");

endmodule // nest_status

// *** rtl/vectored_interrupt_priority.sv ***
// The implementer's own choice: register access over APB.
`timescale 1ns/10ps
module vectored_interrupt_priority #(
  parameter int NSRC = vic_pkg::NSRC
) (
  input  wire logic            pclk,
  input  wire logic            presetn,
  input  wire logic            psel,
  input  wire logic            penable,
  input  wire logic            pwrite,
  input  wire logic [31:0]     paddr,
  input  wire logic [31:0]     pwdata,
  output logic      [31:0]     prdata,
  output logic                 pready,
  output logic                 pslverr,
  input  wire logic [NSRC-1:0] normal_sources,
  input  wire logic [NSRC-1:0] fast_sources,
  output logic                 normal_irq,
  output logic                 fast_interrupt,
  output logic                 fast_nest_enable
);

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  logic [31:0] base_q;
  logic [31:0] prio_a_q;
  logic [31:0] prio_b_q;
  logic [31:0] prio_c_q;
  logic [31:0] ctrl_q;
  logic [31:0] prdata_q;
  logic [2:0]  rd_level_q;
  logic        rd_valid_q;
  logic        normal_irq_q;
  logic        fast_irq_q;
  logic [7:0]  stat_q;
  logic [7:0]  lvl_blocked;

  winner_if win ();

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  wire setup     = psel && !penable;
  wire access    = psel && penable;
  wire hit_base  = (paddr == vic_pkg::OFS_BASE);
  wire hit_vec   = (paddr == vic_pkg::OFS_VEC);
  wire hit_pa    = (paddr == vic_pkg::OFS_PA);
  wire hit_pb    = (paddr == vic_pkg::OFS_PB);
  wire hit_pc    = (paddr == vic_pkg::OFS_PC);
  wire hit_ctrl  = (paddr == vic_pkg::OFS_CTRL);
  wire hit_stat  = (paddr == vic_pkg::OFS_STAT);
  wire hit_any   = hit_base | hit_vec | hit_pa | hit_pb | hit_pc | hit_ctrl | hit_stat;
  wire wr_en     = access && pwrite && hit_any;
  wire rd_vec    = access && !pwrite && hit_vec;
  wire nest_en   = ctrl_q[vic_pkg::BIT_NORMAL_NEST];
  wire fast_any  = |fast_sources;

  // Zero wait states; a miss answers with an error and reads zero
  assign pready  = 1'b1;
  assign pslverr = access && !hit_any;
  assign prdata  = prdata_q;

  // ----------------------------------------------------------------
  // Priority fields per source
  // ----------------------------------------------------------------
  logic [71:0]      prio_all;
  logic [3*NSRC-1:0] src_level;
  logic [3*NSRC-1:0] sel_level;
  logic [NSRC-1:0]  eligible;

  // Field f sits at nibble f of the three registers taken as one word
  for (genvar f = 0; f < vic_pkg::NFIELD; f++)
  begin : g_field
    if (f < 8)
    begin : g_a
      assign prio_all[3*f +: 3] = prio_a_q[vic_pkg::PRIO_STRIDE*f +: 3];
    end
    else if (f < 16)
    begin : g_b
      assign prio_all[3*f +: 3] = prio_b_q[vic_pkg::PRIO_STRIDE*(f-8) +: 3];
    end
    else
    begin : g_c
      assign prio_all[3*f +: 3] = prio_c_q[vic_pkg::PRIO_STRIDE*(f-16) +: 3];
    end
  end

  for (genvar s = 0; s < NSRC; s++)
  begin : g_src
    localparam logic [4:0] FLD = vic_pkg::SRC_FIELD[5*s +: 5];
    if (FLD == vic_pkg::FIELD_NONE)
    begin : g_fixed
      // Sources without a field sit at the least urgent level
      assign src_level[3*s +: 3] = vic_pkg::UNPRIO_LEVEL;
    end
    else
    begin : g_prog
      assign src_level[3*s +: 3] = prio_all[3*FLD +: 3];
    end
    // Nesting off: all levels equal, so plain source order decides
    assign sel_level[3*s +: 3] = nest_en ? src_level[3*s +: 3] : 3'h0;
    assign eligible[s] = normal_sources[s] &&
                         !(nest_en && lvl_blocked[src_level[3*s +: 3]]);
  end

  prio_select #(
    .NSRC     (NSRC)
  ) u_select (
    .pclk     (pclk),
    .presetn  (presetn),
    .eligible (eligible),
    .levels   (sel_level),
    .w        (win.producer)
  );

  // ----------------------------------------------------------------
  // Nesting status
  // ----------------------------------------------------------------
  wire stat_set = rd_vec && nest_en && rd_valid_q;
  wire stat_clr = wr_en && hit_stat;

  nest_status u_status (
    .pclk      (pclk),
    .presetn   (presetn),
    .set_en    (stat_set),
    .set_level (rd_level_q),
    .clr_en    (stat_clr),
    .clr_mask  (pwdata[7:0]),
    .stat_q    (stat_q),
    .blocked   (lvl_blocked)
  );

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  wire [31:0] vec_word = {9'h000, base_q[15:0], win.src, 2'b00};
  wire [31:0] rd_data  = hit_base ? base_q :
                         hit_vec  ? vec_word :
                         hit_pa   ? prio_a_q :
                         hit_pb   ? prio_b_q :
                         hit_pc   ? prio_c_q :
                         hit_ctrl ? ctrl_q :
                         hit_stat ? {24'h000000, stat_q} :
                                    32'h00000000;

  // Vector and its level are frozen in the setup cycle so the status
  // bit set at the access edge matches the value software sees
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata_q   <= vic_pkg::RST_REG;
      rd_level_q <= 3'h0;
      rd_valid_q <= 1'b0;
    end
    else if (setup)
    begin
      prdata_q   <= pwrite ? 32'h00000000 : rd_data;
      rd_level_q <= win.level;
      rd_valid_q <= win.valid;
    end
  end

  // ----------------------------------------------------------------
  // Writable registers
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      base_q   <= vic_pkg::RST_REG;
      prio_a_q <= vic_pkg::RST_REG;
      prio_b_q <= vic_pkg::RST_REG;
      prio_c_q <= vic_pkg::RST_REG;
      ctrl_q   <= vic_pkg::RST_REG;
    end
    else if (wr_en)
    begin
      if (hit_base)
        base_q   <= pwdata & vic_pkg::MASK_BASE;
      if (hit_pa)
        prio_a_q <= pwdata & vic_pkg::MASK_PA;
      if (hit_pb)
        prio_b_q <= pwdata & vic_pkg::MASK_PB;
      if (hit_pc)
        prio_c_q <= pwdata & vic_pkg::MASK_PC;
      if (hit_ctrl)
        ctrl_q   <= pwdata & vic_pkg::MASK_CTRL;
    end
  end

  // ----------------------------------------------------------------
  // Core request lines
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      normal_irq_q <= 1'b0;
      fast_irq_q   <= 1'b0;
    end
    else
    begin
      normal_irq_q <= win.valid && !fast_any;
      fast_irq_q   <= fast_any;
    end
  end

  assign normal_irq       = normal_irq_q;
  assign fast_interrupt   = fast_irq_q;
  assign fast_nest_enable = ctrl_q[vic_pkg::BIT_FAST_NEST];

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_vec_fields;
    setup && !pwrite && hit_vec ##1 access |->
      prdata[31:23] == 9'h000 && prdata[1:0] == 2'b00 && prdata[22:7] == base_q[15:0];
  endproperty
  a_vec_fields: assert property (p_vec_fields) else $error("vector read fields wrong");

  property p_base_upper;
    access && !pwrite && hit_base |-> prdata[31:16] == 16'h0000;
  endproperty
  a_base_upper: assert property (p_base_upper) else $error("base upper bits not zero");

  property p_prio_a;
    wr_en && hit_pa |=> prio_a_q == ($past(pwdata) & vic_pkg::MASK_PA);
  endproperty
  a_prio_a: assert property (p_prio_a) else $error("priority group a not stored");

  property p_prio_b;
    wr_en && hit_pb |=> prio_b_q == ($past(pwdata) & vic_pkg::MASK_PB);
  endproperty
  a_prio_b: assert property (p_prio_b) else $error("priority group b not stored");

  property p_prio_c;
    wr_en && hit_pc |=> prio_c_q == ($past(pwdata) & vic_pkg::MASK_PC);
  endproperty
  a_prio_c: assert property (p_prio_c) else $error("priority group c not stored");

  property p_timer1_level;
    nest_en && win.valid && win.src == vic_pkg::TIMER1_SRC |-> win.level == prio_a_q[18:16];
  endproperty
  a_timer1_level: assert property (p_timer1_level) else $error("timer1 level mismatch");

  property p_fast_wins;
    fast_any |=> fast_interrupt && !normal_irq;
  endproperty
  a_fast_wins: assert property (p_fast_wins) else $error("normal not held off by fast");

  property p_no_nest;
    !nest_en && (|normal_sources) && !fast_any |=> normal_irq;
  endproperty
  a_no_nest: assert property (p_no_nest) else $error("unnested normal not delivered");

  property p_blocked;
    nest_en && win.valid |-> !lvl_blocked[win.level];
  endproperty
  a_blocked: assert property (p_blocked) else $error("blocked level selected");

  property p_read_sets;
    rd_vec && nest_en && rd_valid_q |=> stat_q[$past(rd_level_q)];
  endproperty
  a_read_sets: assert property (p_read_sets) else $error("vector read did not set status");

  // ----------------------------------------------------------------
  // Checks on storage, selection and nesting
  // ----------------------------------------------------------------
  property p_base_store;
    wr_en && hit_base |=> base_q == ($past(pwdata) & vic_pkg::MASK_BASE);
  endproperty
  a_base_store: assert property (p_base_store) else $error("base not stored");

  property p_ctrl_store;
    wr_en && hit_ctrl |=> ctrl_q == ($past(pwdata) & vic_pkg::MASK_CTRL);
  endproperty
  a_ctrl_store: assert property (p_ctrl_store) else $error("control not stored");

  property p_vec_src;
    setup && !pwrite && hit_vec ##1 access |-> prdata[6:2] == $past(win.src);
  endproperty
  a_vec_src: assert property (p_vec_src) else $error("vector source field wrong");

  property p_timer0_level;
    nest_en && win.valid && win.src == 5'h02 |-> win.level == prio_a_q[14:12];
  endproperty
  a_timer0_level: assert property (p_timer0_level) else $error("timer0 level mismatch");

  property p_uart_level;
    nest_en && win.valid && win.src == 5'h0A |-> win.level == prio_b_q[14:12];
  endproperty
  a_uart_level: assert property (p_uart_level) else $error("uart level mismatch");

  // Sources with no field lose to any programmed level below 7
  property p_unprio_level;
    nest_en && win.valid && win.src == 5'h00 |-> win.level == vic_pkg::UNPRIO_LEVEL;
  endproperty
  a_unprio_level: assert property (p_unprio_level) else $error("fixed level wrong");

  property p_free_when_off;
    !nest_en |-> eligible == normal_sources;
  endproperty
  a_free_when_off: assert property (p_free_when_off) else $error("blocking while off");

  property p_irq_follows;
    !fast_any |=> normal_irq == $past(win.valid);
  endproperty
  a_irq_follows: assert property (p_irq_follows) else $error("normal request lost");

  property p_fast_quiet;
    !fast_any |=> !fast_interrupt;
  endproperty
  a_fast_quiet: assert property (p_fast_quiet) else $error("fast request without source");

  // Status bits move only through a vector read or a status write
  property p_set_on_read;
    !(rd_vec && nest_en) |=> (stat_q & ~$past(stat_q)) == 8'h00;
  endproperty
  a_set_on_read: assert property (p_set_on_read) else $error("stray status set");

  property p_clr_on_write;
    !stat_clr |=> (~stat_q & $past(stat_q)) == 8'h00;
  endproperty
  a_clr_on_write: assert property (p_clr_on_write) else $error("stray status clear");

endmodule // vectored_interrupt_priority

// *** sim/core_model.sv ***
`timescale 1ns/10ps
module core_model (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       normal_irq,
  input  wire logic       fast_interrupt,
  output logic      [1:0] mode_q
);
  // ----------------------------------------------------------------
  // Exception entry
  // ----------------------------------------------------------------
  // The core takes the fast entry whenever both lines are up
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      mode_q <= 2'h0;
    else if (fast_interrupt)
      mode_q <= 2'h2;
    else if (normal_irq)
      mode_q <= 2'h1;
    else
      mode_q <= 2'h0;
  end
endmodule // core_model

// *** sim/test_vectored_interrupt_priority.sv ***
`timescale 1ns/10ps
`define CHK(nm, ex, got) begin n_compared++; if ((got) !== (ex)) begin miscompares++; \
  $display("ERROR %s expected %h seen %h", nm, ex, got); end end
module test_vectored_interrupt_priority;
  logic                     pclk = 1'b0, presetn = 1'b0;
  logic                     psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [31:0]              paddr = 32'h0, pwdata = 32'h0;
  logic [31:0]              prdata, rd;
  logic                     pready, pslverr, er;
  logic [vic_pkg::NSRC-1:0] normal_sources = '0, fast_sources = '0;
  logic                     normal_irq, fast_interrupt, fast_nest_enable;
  logic [1:0]               mode_q;
  int                       miscompares = 0, n_compared = 0;

  always #2 pclk = ~pclk;

  vectored_interrupt_priority #(.NSRC(vic_pkg::NSRC)) uut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .normal_sources(normal_sources), .fast_sources(fast_sources), .normal_irq(normal_irq),
    .fast_interrupt(fast_interrupt), .fast_nest_enable(fast_nest_enable));

  core_model partner (.pclk(pclk), .presetn(presetn), .normal_irq(normal_irq),
    .fast_interrupt(fast_interrupt), .mode_q(mode_q));

  // ----------------------------------------------------------------
  // Bus and stimulus helpers
  // ----------------------------------------------------------------
  // Request held until pready is seen; a slave that never answers is cut by the watchdog
  task automatic apb(input logic w, input logic [31:0] a, d, output logic [31:0] r,
                     output logic e);
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask

  task automatic wr(input logic [31:0] a, d);
    apb(1'b1, a, d, rd, er);
  endtask

  task automatic rdchk(input string nm, input logic [31:0] a, ex);
    apb(1'b0, a, 32'h0, rd, er);
    `CHK(nm, ex, rd)
  endtask

  // Allows the registered request lines and the winner to settle
  task automatic src(input logic [19:0] n, f);
    @(posedge pclk);
    normal_sources <= n; fast_sources <= f;
    repeat (3) @(posedge pclk);
    #1;
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    logic [31:0] a [7] = '{vic_pkg::OFS_PA, vic_pkg::OFS_PB, vic_pkg::OFS_PC,
      vic_pkg::OFS_CTRL, vic_pkg::OFS_STAT, vic_pkg::OFS_BASE, vic_pkg::OFS_VEC};
    foreach (a[i]) rdchk("reset value", a[i], 32'h0);
    $display("test reset done");
  endtask

  task automatic t_regs;
    wr(vic_pkg::OFS_PA, 32'hFFFFFFFF);
    rdchk("group a", vic_pkg::OFS_PA, 32'h07777070);
    wr(vic_pkg::OFS_PB, 32'hFFFFFFFF);
    rdchk("group b", vic_pkg::OFS_PB, 32'h77777700);
    wr(vic_pkg::OFS_PC, 32'hFFFFFFFF);
    rdchk("group c", vic_pkg::OFS_PC, 32'h00007777);
    wr(vic_pkg::OFS_BASE, 32'hFFFFFFFF);
    rdchk("base", vic_pkg::OFS_BASE, 32'h0000FFFF);
    wr(vic_pkg::OFS_VEC, 32'hFFFFFFFF);
    rdchk("vector ro", vic_pkg::OFS_VEC, {9'h000, 16'hFFFF, 5'h00, 2'h0});
    wr(vic_pkg::OFS_CTRL, 32'h00000002);
    rdchk("control", vic_pkg::OFS_CTRL, 32'h00000002);
    `CHK("fast nest", 1'b1, fast_nest_enable)
    apb(1'b1, 32'hFFFF002C, 32'hFFFFFFFF, rd, er);
    `CHK("slverr write", 1'b1, er)
    apb(1'b0, 32'hFFFF002C, 32'h0, rd, er);
    `CHK("slverr read", 1'b1, er)
    `CHK("unmapped data", 32'h0, rd)
    wr(vic_pkg::OFS_CTRL, 32'h0);
    wr(vic_pkg::OFS_PA, 32'h0);
    wr(vic_pkg::OFS_PB, 32'h0);
    wr(vic_pkg::OFS_PC, 32'h0);
    $display("test registers done");
  endtask

  task automatic t_vector;
    wr(vic_pkg::OFS_BASE, 32'h0000ABCD);
    src(20'h01100, 20'h0);
    rdchk("vector", vic_pkg::OFS_VEC, {9'h000, 16'hABCD, 5'h08, 2'h0});
    rdchk("no nest status", vic_pkg::OFS_STAT, 32'h0);
    `CHK("normal irq", 1'b1, normal_irq)
    `CHK("core normal", 2'h1, mode_q)
    src(20'h01100, 20'h00008);
    `CHK("irq under fast", 1'b0, normal_irq)
    `CHK("fast irq", 1'b1, fast_interrupt)
    `CHK("core fast", 2'h2, mode_q)
    src(20'h0, 20'h0);
    wr(vic_pkg::OFS_BASE, 32'h0);
    $display("test vector done");
  endtask

  task automatic t_prio;
    wr(vic_pkg::OFS_CTRL, 32'h1);
    wr(vic_pkg::OFS_PA, 32'h00252000);
    wr(vic_pkg::OFS_PB, 32'h00001000);
    src(20'h0010C, 20'h0);
    rdchk("tie", vic_pkg::OFS_VEC, {25'h0, 5'h02, 2'h0});
    rdchk("status l2", vic_pkg::OFS_STAT, 32'h4);
    src(20'h0010C, 20'h0);
    `CHK("blocked irq", 1'b0, normal_irq)
    src(20'h0050C, 20'h0);
    `CHK("urgent irq", 1'b1, normal_irq)
    rdchk("level 1", vic_pkg::OFS_VEC, {25'h0, 5'h0A, 2'h0});
    rdchk("status l1", vic_pkg::OFS_STAT, 32'h6);
    wr(vic_pkg::OFS_STAT, 32'hFF);
    rdchk("clear one", vic_pkg::OFS_STAT, 32'h4);
    wr(vic_pkg::OFS_STAT, 32'hFF);
    rdchk("clear two", vic_pkg::OFS_STAT, 32'h0);
    $display("test priority done");
  endtask

  task automatic build_09;
    src(20'h00100, 20'h0);
    rdchk("timer1", vic_pkg::OFS_VEC, {25'h0, 5'h08, 2'h0});
    src(20'h00500, 20'h0);
    rdchk("past block", vic_pkg::OFS_VEC, {25'h0, 5'h0A, 2'h0});
    rdchk("status 09", vic_pkg::OFS_STAT, 32'h9);
  endtask

  task automatic t_nest;
    wr(vic_pkg::OFS_PA, 32'h00030000);
    wr(vic_pkg::OFS_PB, 32'h0);
    build_09;
    wr(vic_pkg::OFS_STAT, 32'hFF);
    rdchk("ff once", vic_pkg::OFS_STAT, 32'h8);
    wr(vic_pkg::OFS_STAT, 32'hFF);
    rdchk("ff twice", vic_pkg::OFS_STAT, 32'h0);
    build_09;
    wr(vic_pkg::OFS_STAT, 32'h08);
    rdchk("masked clear", vic_pkg::OFS_STAT, 32'h1);
    wr(vic_pkg::OFS_STAT, 32'hFF);
    rdchk("last clear", vic_pkg::OFS_STAT, 32'h0);
    src(20'h00001, 20'h0);
    rdchk("fixed source", vic_pkg::OFS_VEC, 32'h0);
    rdchk("status l7", vic_pkg::OFS_STAT, 32'h80);
    wr(vic_pkg::OFS_STAT, 32'hFF);
    rdchk("l7 clear", vic_pkg::OFS_STAT, 32'h0);
    wr(vic_pkg::OFS_CTRL, 32'h0);
    src(20'h0, 20'h0);
    $display("test nesting done");
  endtask

  // Reset in mid-run must drop programmed levels, control and status
  task automatic t_rerun;
    wr(vic_pkg::OFS_CTRL, 32'h1);
    wr(vic_pkg::OFS_PA, 32'h00030000);
    src(20'h00100, 20'h0);
    rdchk("pre reset vector", vic_pkg::OFS_VEC, {25'h0, 5'h08, 2'h0});
    rdchk("pre reset status", vic_pkg::OFS_STAT, 32'h8);
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    rdchk("reset status", vic_pkg::OFS_STAT, 32'h0);
    rdchk("reset control", vic_pkg::OFS_CTRL, 32'h0);
    rdchk("reset group a", vic_pkg::OFS_PA, 32'h0);
    src(20'h0, 20'h0);
    $display("test mid-run reset done");
  endtask

  // ----------------------------------------------------------------
  // Verdict
  // ----------------------------------------------------------------
  task automatic end_of_test;
    $display("compared %0d mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // The whole sequence needs well under a thousand cycles
  initial
  begin
    #(4 * 20000);
    miscompares++;
    end_of_test;
  end

  initial
  begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    t_reset;
    t_regs;
    t_vector;
    t_prio;
    t_nest;
    t_rerun;
    end_of_test;
  end
endmodule // test_vectored_interrupt_priority
